// [core/ppsm_pkg.sv]
// Shared constants for the PHY port select block.
`default_nettype none
package ppsm_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam int          ADDR_W         = 5;
  localparam logic [4:0]  OFS_CONFIG     = 5'h00;
  localparam logic [4:0]  OFS_TX_CTRL    = 5'h04;
  localparam logic [4:0]  OFS_PHY_STAT   = 5'h08;
  localparam logic [4:0]  OFS_RX_STAT    = 5'h0c;
  localparam logic [4:0]  OFS_TX_DATA    = 5'h10;
  localparam logic [4:0]  OFS_MGMT       = 5'h14;
  // ==========================================================
  // Field positions
  localparam int CFG_PORT_SEL_BIT = 15;
  localparam int CFG_STEP_BIT     = 10;
  localparam int CFG_AUI_BIT      = 8;
  localparam int TCR_WRAP_BIT     = 1;
  localparam int PHY_LINK_BIT     = 14;
  localparam int PHY_BUSY_BIT     = 0;
  localparam int PHY_CARRIER_BIT  = 1;
  localparam int PHY_CLASH_BIT    = 2;
  localparam int RXS_BADCRC_BIT   = 13;
  localparam int RXS_VALID_BIT    = 8;
  localparam int MGMT_OUT_BIT     = 0;
  localparam int MGMT_IN_BIT      = 1;
  // ==========================================================
  // Reset values
  localparam logic [15:0] CONFIG_RST  = 16'h0000;
  localparam logic [15:0] TX_CTRL_RST = 16'h0000;
  // ==========================================================
  // Positions of the pins in the synchroniser vector
  localparam int SI_ECS  = 0;
  localparam int SI_ECOL = 1;
  localparam int SI_ERXD = 2;
  localparam int SI_ETXC = 3;
  localparam int SI_ERXC = 4;
  localparam int SI_LINK = 5;
  localparam int SI_FCRS = 6;
  localparam int SI_RXDV = 7;
  localparam int SI_RXER = 8;
  localparam int SI_FCOL = 9;
  localparam int SI_NTXC = 10;
  localparam int SI_NRXC = 11;
  localparam int SI_MDI  = 12;
  localparam int SI_RXN  = 13;
  localparam int SYNC_W  = 17;
  // ==========================================================
  // Transmit sequencer
  typedef enum logic [1:0] {TX_IDLE, TX_DEFER, TX_SHIFT} ppsm_tx_state_t;
endpackage
`default_nettype wire

// [core/ppsm_pin_if.sv]
// Synchronised pin levels and edges passed to the main block.
`timescale 1ns/1ps
`default_nettype none
interface ppsm_pin_if #(parameter int W = 1);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// [core/ppsm_pin_sync.sv]
// Two-flop synchroniser bank with edge detection for outside pins.
`timescale 1ns/1ps
`default_nettype none
module ppsm_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] pins_in,
  ppsm_pin_if.src           pin
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] last_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end else begin
      meta_r <= pins_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign pin.lvl  = sync_r;
  assign pin.rise = sync_r & ~last_r;
  assign pin.fall = ~sync_r & last_r;
endmodule
`default_nettype wire

// [core/ppsm_port_mux.sv]
// Port select between serial encoder/decoder and nibble PHY port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - nibble_port_sel follows config bit 15; high picks nibble port.
// - Encoder/decoder inputs are ignored while nibble port is selected.
// - Serial transmit data leaves one NRZ bit at a time.
// - wrap_back_out follows transmit control bit 1 in either mode.
// - link_fail_in shows in phy status bit 14 in either mode.
// - full_step_n is the inverse of config bit 10.
// - attach_unit_sel follows config bit 8.
// - Select, attach and step outputs hold stored config values.
// - fast_tx_envelope covers each fast frame; low in serial mode.
// - fast_carrier_sense gates deferral in nibble mode only.
// - Receive nibbles are taken only while rx_dv is high.
// - fast_clash_detect is the collision input in nibble mode.
// - In nibble mode, transmit data leaves as four-bit nibbles.
// - Receive nibbles are taken in nibble mode only.
// - Management data has separate outgoing and incoming pins.
// - endec_tx_envelope stays low while nibble port is selected.
// - rx_er discards the rest of the frame and sets receive status bit 13.
module ppsm_port_mux (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [4:0]  avm_address,
  input  wire logic        avm_read,
  input  wire logic        avm_write,
  input  wire logic [31:0] avm_writedata,
  input  wire logic [3:0]  avm_byteenable,
  output logic      [31:0] avm_readdata,
  output logic             avm_waitrequest,
  output logic             endec_tx_envelope,
  output logic             endec_serial_out,
  input  wire logic        endec_carrier_sense,
  input  wire logic        endec_clash_detect,
  input  wire logic        endec_serial_in,
  input  wire logic        endec_send_clock,
  input  wire logic        endec_recv_clock,
  output logic             wrap_back_out,
  input  wire logic        link_fail_in,
  output logic             full_step_n,
  output logic             nibble_port_sel,
  output logic             attach_unit_sel,
  output logic             fast_tx_envelope,
  input  wire logic        fast_carrier_sense,
  input  wire logic        rx_dv,
  input  wire logic        rx_er,
  input  wire logic        fast_clash_detect,
  output logic      [3:0]  tx_nibble,
  input  wire logic        nibble_tx_clock,
  input  wire logic        nibble_rx_clock,
  input  wire logic [3:0]  rx_nibble,
  input  wire logic        mgmt_serial_in,
  output logic             mgmt_serial_out
);
  // ==========================================================
  // Pin synchronisers
  ppsm_pin_if #(.W(ppsm_pkg::SYNC_W)) pin ();

  ppsm_pin_sync #(.W(ppsm_pkg::SYNC_W)) u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pins_in ({rx_nibble, mgmt_serial_in, nibble_rx_clock,
               nibble_tx_clock, fast_clash_detect, rx_er, rx_dv,
               fast_carrier_sense, link_fail_in, endec_recv_clock,
               endec_send_clock, endec_serial_in, endec_clash_detect,
               endec_carrier_sense}),
    .pin     (pin)
  );

  logic       sel;
  logic       launch;
  logic       carrier;
  logic       clash;
  logic       mii_rx_edge;
  logic       ser_rx_edge;
  logic [3:0] rxn;

  assign sel = nibble_port_sel;
  assign rxn = pin.lvl[ppsm_pkg::SI_RXN +: 4];
  // Only the selected port's clocks and status pins reach the logic.
  assign launch = sel ? pin.fall[ppsm_pkg::SI_NTXC]
                      : pin.fall[ppsm_pkg::SI_ETXC];
  assign carrier = sel ? pin.lvl[ppsm_pkg::SI_FCRS]
                       : pin.lvl[ppsm_pkg::SI_ECS];
  assign clash = sel ? pin.lvl[ppsm_pkg::SI_FCOL]
                     : pin.lvl[ppsm_pkg::SI_ECOL];
  assign mii_rx_edge = sel & pin.rise[ppsm_pkg::SI_NRXC];
  assign ser_rx_edge = ~sel & pin.rise[ppsm_pkg::SI_ERXC];

  // ==========================================================
  // Bus slave
  logic [15:0] config_r;
  logic [15:0] tx_ctrl_r;
  logic        hold_full_r;
  logic        clash_seen_r;
  logic        rx_valid_r;
  logic        rx_bad_r;
  logic [7:0]  rx_byte_r;
  logic        taken;
  logic        tx_push;
  logic        stall;
  logic [31:0] rd_nxt;

  // A data write waits while the holding byte is still full.
  assign stall = avm_write && (avm_address == ppsm_pkg::OFS_TX_DATA)
                 && hold_full_r;
  assign taken = !avm_waitrequest && (avm_read || avm_write);
  assign tx_push = taken && avm_write && avm_byteenable[0]
                   && (avm_address == ppsm_pkg::OFS_TX_DATA);

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd[15:0] & m);
  endfunction

  always_comb begin
    rd_nxt = '0;
    unique case (avm_address)
      ppsm_pkg::OFS_CONFIG:  rd_nxt[15:0] = config_r;
      ppsm_pkg::OFS_TX_CTRL: rd_nxt[15:0] = tx_ctrl_r;
      ppsm_pkg::OFS_PHY_STAT: begin
        rd_nxt[ppsm_pkg::PHY_LINK_BIT] = pin.lvl[ppsm_pkg::SI_LINK];
        rd_nxt[ppsm_pkg::PHY_BUSY_BIT]    = hold_full_r;
        rd_nxt[ppsm_pkg::PHY_CARRIER_BIT] = carrier;
        rd_nxt[ppsm_pkg::PHY_CLASH_BIT]   = clash_seen_r;
      end
      ppsm_pkg::OFS_RX_STAT: begin
        rd_nxt[7:0] = rx_byte_r;
        rd_nxt[ppsm_pkg::RXS_VALID_BIT]  = rx_valid_r;
        rd_nxt[ppsm_pkg::RXS_BADCRC_BIT] = rx_bad_r;
      end
      ppsm_pkg::OFS_MGMT: begin
        rd_nxt[ppsm_pkg::MGMT_OUT_BIT] = mgmt_serial_out;
        rd_nxt[ppsm_pkg::MGMT_IN_BIT]  = pin.lvl[ppsm_pkg::SI_MDI];
      end
      default: rd_nxt = '0;
    endcase
  end

  // Every access is answered one cycle after it is seen, except a data write, which waits while the holding byte is still full.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      avm_waitrequest <= 1'b1;
      avm_readdata    <= '0;
    end else begin
      avm_waitrequest <= !((avm_read || avm_write) && avm_waitrequest
                           && !stall);
      if (avm_read && avm_waitrequest) begin
        avm_readdata <= rd_nxt;
      end
    end
  end

  // Configuration is held here so the pin outputs stay put.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_r  <= ppsm_pkg::CONFIG_RST;
      tx_ctrl_r <= ppsm_pkg::TX_CTRL_RST;
      mgmt_serial_out <= 1'b0;
    end else if (taken && avm_write) begin
      if (avm_address == ppsm_pkg::OFS_CONFIG) begin
        config_r <= merge16(config_r, avm_writedata, avm_byteenable);
      end
      if (avm_address == ppsm_pkg::OFS_TX_CTRL) begin
        tx_ctrl_r <= merge16(tx_ctrl_r, avm_writedata, avm_byteenable);
      end
      if (avm_address == ppsm_pkg::OFS_MGMT && avm_byteenable[0]) begin
        mgmt_serial_out <= avm_writedata[ppsm_pkg::MGMT_OUT_BIT];
      end
    end
  end

  // ==========================================================
  // Static pin outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      nibble_port_sel <= ppsm_pkg::CONFIG_RST[ppsm_pkg::CFG_PORT_SEL_BIT];
      attach_unit_sel <= ppsm_pkg::CONFIG_RST[ppsm_pkg::CFG_AUI_BIT];
      full_step_n     <= ~ppsm_pkg::CONFIG_RST[ppsm_pkg::CFG_STEP_BIT];
      wrap_back_out   <= ppsm_pkg::TX_CTRL_RST[ppsm_pkg::TCR_WRAP_BIT];
    end else begin
      nibble_port_sel <= config_r[ppsm_pkg::CFG_PORT_SEL_BIT];
      attach_unit_sel <= config_r[ppsm_pkg::CFG_AUI_BIT];
      full_step_n     <= ~config_r[ppsm_pkg::CFG_STEP_BIT];
      wrap_back_out   <= tx_ctrl_r[ppsm_pkg::TCR_WRAP_BIT];
    end
  end

  // ==========================================================
  // Transmit
  ppsm_pkg::ppsm_tx_state_t tx_state_r;
  logic [7:0] hold_r;
  logic [7:0] shift_r;
  logic [2:0] unit_cnt_r;
  logic       last_unit;

  assign last_unit = sel ? (unit_cnt_r == 3'h1) : (unit_cnt_r == 3'h7);

  // A collision drops the frame; the remaining byte is flushed too.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_r        <= ppsm_pkg::TX_IDLE;
      hold_r            <= '0;
      hold_full_r       <= 1'b0;
      shift_r           <= '0;
      unit_cnt_r        <= '0;
      endec_tx_envelope <= 1'b0;
      fast_tx_envelope  <= 1'b0;
      endec_serial_out  <= 1'b0;
      tx_nibble         <= '0;
    end else begin
      if (tx_push) begin
        hold_r      <= avm_writedata[7:0];
        hold_full_r <= 1'b1;
      end
      unique case (tx_state_r)
        ppsm_pkg::TX_IDLE: begin
          if (hold_full_r) begin
            tx_state_r <= ppsm_pkg::TX_DEFER;
          end
        end
        ppsm_pkg::TX_DEFER: begin
          if (launch && !carrier) begin
            tx_state_r        <= ppsm_pkg::TX_SHIFT;
            hold_full_r       <= 1'b0;
            unit_cnt_r        <= '0;
            shift_r           <= sel ? {4'h0, hold_r[7:4]}
                                     : {1'b0, hold_r[7:1]};
            endec_serial_out  <= hold_r[0];
            tx_nibble         <= hold_r[3:0];
            fast_tx_envelope  <= sel;
            endec_tx_envelope <= !sel;
          end
        end
        ppsm_pkg::TX_SHIFT: begin
          if (clash) begin
            tx_state_r        <= ppsm_pkg::TX_IDLE;
            hold_full_r       <= 1'b0;
            fast_tx_envelope  <= 1'b0;
            endec_tx_envelope <= 1'b0;
          end else if (launch && last_unit && hold_full_r) begin
            hold_full_r      <= 1'b0;
            unit_cnt_r       <= '0;
            shift_r          <= sel ? {4'h0, hold_r[7:4]}
                                    : {1'b0, hold_r[7:1]};
            endec_serial_out <= hold_r[0];
            tx_nibble        <= hold_r[3:0];
          end else if (launch && last_unit) begin
            tx_state_r        <= ppsm_pkg::TX_IDLE;
            fast_tx_envelope  <= 1'b0;
            endec_tx_envelope <= 1'b0;
          end else if (launch) begin
            unit_cnt_r       <= unit_cnt_r + 3'h1;
            shift_r          <= sel ? {4'h0, shift_r[7:4]}
                                    : {1'b0, shift_r[7:1]};
            endec_serial_out <= shift_r[0];
            tx_nibble        <= shift_r[3:0];
          end
        end
      endcase
      // The unselected port's envelope is forced low.
      if (sel) begin
        endec_tx_envelope <= 1'b0;
      end else begin
        fast_tx_envelope <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clash_seen_r <= 1'b0;
    end else if (tx_state_r == ppsm_pkg::TX_SHIFT && clash) begin
      clash_seen_r <= 1'b1;
    end else if (taken && avm_write && avm_byteenable[0]
                 && avm_address == ppsm_pkg::OFS_PHY_STAT
                 && avm_writedata[ppsm_pkg::PHY_CLASH_BIT]) begin
      clash_seen_r <= 1'b0;
    end
  end

  // ==========================================================
  // Receive
  logic       discard_r;
  logic       half_r;
  logic [3:0] low_nib_r;
  logic [7:0] ser_buf_r;
  logic [2:0] ser_cnt_r;
  logic       byte_done;
  logic [7:0] byte_val;
  logic       bad_set;
  logic       clr_valid;
  logic       clr_bad;

  assign bad_set = mii_rx_edge && pin.lvl[ppsm_pkg::SI_RXDV]
                   && pin.lvl[ppsm_pkg::SI_RXER];
  assign byte_done = (mii_rx_edge && pin.lvl[ppsm_pkg::SI_RXDV]
                      && !pin.lvl[ppsm_pkg::SI_RXER] && !discard_r
                      && half_r)
                     || (ser_rx_edge && pin.lvl[ppsm_pkg::SI_ECS]
                         && ser_cnt_r == 3'h7);
  assign byte_val = sel ? {rxn, low_nib_r}
                        : {pin.lvl[ppsm_pkg::SI_ERXD], ser_buf_r[7:1]};
  assign clr_valid = taken && avm_write && avm_byteenable[1]
                     && avm_address == ppsm_pkg::OFS_RX_STAT
                     && avm_writedata[ppsm_pkg::RXS_VALID_BIT];
  assign clr_bad = taken && avm_write && avm_byteenable[1]
                   && avm_address == ppsm_pkg::OFS_RX_STAT
                   && avm_writedata[ppsm_pkg::RXS_BADCRC_BIT];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      discard_r <= 1'b0;
      half_r    <= 1'b0;
      low_nib_r <= '0;
    end else if (mii_rx_edge) begin
      if (!pin.lvl[ppsm_pkg::SI_RXDV]) begin
        discard_r <= 1'b0;
        half_r    <= 1'b0;
      end else if (pin.lvl[ppsm_pkg::SI_RXER]) begin
        discard_r <= 1'b1;
      end else if (!discard_r) begin
        low_nib_r <= rxn;
        half_r    <= !half_r;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ser_buf_r <= '0;
      ser_cnt_r <= '0;
    end else if (ser_rx_edge) begin
      if (pin.lvl[ppsm_pkg::SI_ECS]) begin
        ser_buf_r <= {pin.lvl[ppsm_pkg::SI_ERXD], ser_buf_r[7:1]};
        ser_cnt_r <= ser_cnt_r + 3'h1;
      end else begin
        ser_cnt_r <= '0;
      end
    end
  end

  // Hardware setting a flag wins over a clear in the same cycle.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_byte_r  <= '0;
      rx_valid_r <= 1'b0;
      rx_bad_r   <= 1'b0;
    end else begin
      if (byte_done) begin
        rx_byte_r  <= byte_val;
        rx_valid_r <= 1'b1;
      end else if (clr_valid) begin
        rx_valid_r <= 1'b0;
      end
      if (bad_set) begin
        rx_bad_r <= 1'b1;
      end else if (clr_bad) begin
        rx_bad_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  property p_sel_cfg;
    @(posedge sys_clk) disable iff (!reset_n)
    taken && avm_write && avm_byteenable[1]
      && avm_address == ppsm_pkg::OFS_CONFIG
    |=> ##1 nibble_port_sel == $past(avm_writedata[15], 2)
        && full_step_n == !$past(avm_writedata[10], 2)
        && attach_unit_sel == $past(avm_writedata[8], 2);
  endproperty
  a_sel_cfg: assert property (p_sel_cfg)
    else $error("config pins do not follow written config");

  property p_wrap;
    @(posedge sys_clk) disable iff (!reset_n)
    taken && avm_write && avm_byteenable[0]
      && avm_address == ppsm_pkg::OFS_TX_CTRL
    |=> ##1 wrap_back_out == $past(avm_writedata[1], 2);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap back output does not follow control bit");

  property p_endec_env_low;
    @(posedge sys_clk) disable iff (!reset_n)
    nibble_port_sel && $past(nibble_port_sel) |-> !endec_tx_envelope;
  endproperty
  a_endec_env_low: assert property (p_endec_env_low)
    else $error("serial envelope high in nibble mode");

  property p_fast_env_low;
    @(posedge sys_clk) disable iff (!reset_n)
    !nibble_port_sel && !$past(nibble_port_sel) |-> !fast_tx_envelope;
  endproperty
  a_fast_env_low: assert property (p_fast_env_low)
    else $error("fast envelope high in serial mode");

  property p_link;
    @(posedge sys_clk) disable iff (!reset_n)
    avm_read && avm_waitrequest && !stall
      && avm_address == ppsm_pkg::OFS_PHY_STAT
    |=> avm_readdata[14] == $past(pin.lvl[ppsm_pkg::SI_LINK]);
  endproperty
  a_link: assert property (p_link)
    else $error("link bit does not show link pin");

  property p_launch_only;
    @(posedge sys_clk) disable iff (!reset_n)
    !$stable(endec_serial_out) || !$stable(tx_nibble) |-> $past(launch);
  endproperty
  a_launch_only: assert property (p_launch_only)
    else $error("transmit data moved without a clock fall");

  property p_ser_ignored;
    @(posedge sys_clk) disable iff (!reset_n)
    nibble_port_sel && $past(nibble_port_sel) |-> $stable(ser_cnt_r);
  endproperty
  a_ser_ignored: assert property (p_ser_ignored)
    else $error("serial receive moved in nibble mode");

  property p_bad_crc;
    @(posedge sys_clk) disable iff (!reset_n)
    bad_set |=> rx_bad_r && discard_r ##1 !rx_valid_r || $stable(rx_byte_r);
  endproperty
  a_bad_crc: assert property (p_bad_crc)
    else $error("receive error not reported as bad check");

  property p_dv_frame;
    @(posedge sys_clk) disable iff (!reset_n)
    mii_rx_edge && !pin.lvl[ppsm_pkg::SI_RXDV] |=> !half_r && !byte_done;
  endproperty
  a_dv_frame: assert property (p_dv_frame)
    else $error("nibble taken outside receive data valid");
endmodule
`default_nettype wire

// [dv/ppsm_link_model.sv]
// Link partner model: free link clock, transmit capture, receive driver.
`timescale 1ns/1ps
`default_nettype none
module ppsm_link_model (
  input  wire logic       sel,
  input  wire logic       eenv,
  input  wire logic       esd,
  input  wire logic       fenv,
  input  wire logic [3:0] txn,
  output logic            lclk,
  output logic            ecrs,
  output logic            erxd,
  output logic            dv,
  output logic            er,
  output logic      [3:0] rxn,
  output logic      [7:0] cap,
  output int              ncap
);
  // ==========================================================
  // Clock and idle levels
  // Both ends run their clocks free, so one shared clock is enough here.
  initial begin
    {ecrs, erxd, dv, er, rxn} = 8'h40;
    cap = 8'h00;
    ncap = 0;
    lclk = 1'b0;
    #123;
    forever #200 lclk = ~lclk;
  end
  // ==========================================================
  // Capture at the fall, where the previous unit is still stable.
  always @(negedge lclk) begin
    if (sel ? fenv : eenv) begin
      cap <= sel ? {txn, cap[7:4]} : {esd, cap[7:1]};
      ncap <= ncap + 1;
    end
  end
  // ==========================================================
  // Serial stream carries b, the nibble lines carry its inverse.
  task automatic rx(input logic [7:0] b, input logic e);
    for (int i = 0; i < 8; i++) begin
      @(negedge lclk);
      ecrs <= 1'b1;
      erxd <= b[i];
      dv <= 1'b1;
      er <= e && i == 4;
      rxn <= i[0] ? ~b[7:4] : ~b[3:0];
    end
    @(negedge lclk);
    {ecrs, dv, er} <= 3'h0;
    erxd <= 1'b1;
    rxn <= b[7:4];
  endtask
endmodule
`default_nettype wire

// [dv/phy_port_select_mux_bench.sv]
// Self-checking bench for the PHY port select block.
`timescale 1ns/1ps
`default_nettype none
module phy_port_select_mux_bench;
  logic [4:0]  avm_address;
  logic [31:0] avm_writedata, avm_readdata, q;
  logic [3:0]  avm_byteenable, tx_nibble, rx_nibble;
  logic [7:0]  cap;
  int          ncap, error_cnt, checked;
  logic        sys_clk, reset_n, avm_read, avm_write, avm_waitrequest;
  logic        endec_tx_envelope, endec_serial_out, endec_carrier_sense;
  logic        endec_clash_detect, endec_serial_in, lclk, wrap_back_out;
  logic        link_fail_in, full_step_n, nibble_port_sel, attach_unit_sel;
  logic        fast_tx_envelope, fast_carrier_sense, rx_dv, rx_er;
  logic        bad = 1'b0;
  logic        fast_clash_detect, mgmt_serial_in, mgmt_serial_out;
  ppsm_port_mux u_ppsm_port_mux (
    .sys_clk, .reset_n, .avm_address, .avm_read, .avm_write,
    .avm_writedata, .avm_byteenable, .avm_readdata, .avm_waitrequest,
    .endec_tx_envelope, .endec_serial_out, .endec_carrier_sense,
    .endec_clash_detect, .endec_serial_in, .endec_send_clock(lclk),
    .endec_recv_clock(lclk), .wrap_back_out, .link_fail_in, .full_step_n,
    .nibble_port_sel, .attach_unit_sel, .fast_tx_envelope,
    .fast_carrier_sense, .rx_dv, .rx_er, .fast_clash_detect, .tx_nibble,
    .nibble_tx_clock(lclk), .nibble_rx_clock(lclk), .rx_nibble,
    .mgmt_serial_in, .mgmt_serial_out);
  ppsm_link_model u_ppsm_link_model (
    .sel(nibble_port_sel), .eenv(endec_tx_envelope),
    .esd(endec_serial_out), .fenv(fast_tx_envelope), .txn(tx_nibble),
    .lclk(lclk), .ecrs(endec_carrier_sense), .erxd(endec_serial_in),
    .dv(rx_dv), .er(rx_er), .rxn(rx_nibble), .cap(cap), .ncap(ncap));
  // ==========================================================
  // Clock, envelope watch and tasks
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    if (nibble_port_sel ? endec_tx_envelope : fast_tx_envelope) bad <= 1'b1;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avm_address <= a;
    avm_writedata <= d;
    avm_write <= w;
    avm_read <= !w;
    do begin
      @(posedge sys_clk);
    end while (avm_waitrequest !== 1'b0);
    q = avm_readdata;
    avm_read <= 1'b0;
    avm_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // A nonzero d holds the fast carrier up for d cycles before release.
  task automatic tx(input logic [7:0] b, input int n, input int d);
    int n0;
    n0 = ncap;
    acc(1'b1, ppsm_pkg::OFS_TX_DATA, {24'h0, b});
    repeat (d) @(posedge sys_clk);
    chk(ncap - n0, 0);
    if (d > 0) fast_carrier_sense <= 1'b0;
    while (ncap != n0 + n) begin
      @(posedge sys_clk);
    end
    repeat (20) @(posedge sys_clk);
    chk(ncap - n0, n);
    chk(cap, b);
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish;
  end
  // ==========================================================
  // Test sequence
  initial begin
    {reset_n, avm_read, avm_write, endec_clash_detect, link_fail_in} = 5'h0;
    {fast_carrier_sense, fast_clash_detect, mgmt_serial_in} = 3'h0;
    avm_address = 5'h00;
    avm_writedata = 32'h0;
    avm_byteenable = 4'hf;
    error_cnt = 0;
    checked = 0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk({nibble_port_sel, attach_unit_sel, full_step_n, wrap_back_out}, 4'h2);
    rd(ppsm_pkg::OFS_CONFIG, {16'h0, ppsm_pkg::CONFIG_RST});
    rd(ppsm_pkg::OFS_TX_CTRL, {16'h0, ppsm_pkg::TX_CTRL_RST});
    rd(5'h18, 32'h0);
    link_fail_in <= 1'b1;
    mgmt_serial_in <= 1'b1;
    acc(1'b1, ppsm_pkg::OFS_TX_CTRL, 32'h2);
    acc(1'b1, ppsm_pkg::OFS_MGMT, 32'h1);
    rd(ppsm_pkg::OFS_PHY_STAT, 32'h4000);
    rd(ppsm_pkg::OFS_MGMT, 32'h3);
    chk({wrap_back_out, mgmt_serial_out}, 2'h3);
    fast_carrier_sense <= 1'b1;
    fast_clash_detect <= 1'b1;
    tx(8'ha5, 8, 0);
    u_ppsm_link_model.rx(8'h5a, 1'b0);
    repeat (8) @(posedge sys_clk);
    rd(ppsm_pkg::OFS_RX_STAT, 32'h15a);
    fast_clash_detect <= 1'b0;
    endec_clash_detect <= 1'b1;
    acc(1'b1, ppsm_pkg::OFS_CONFIG, 32'h8500);
    repeat (3) @(posedge sys_clk);
    chk({nibble_port_sel, attach_unit_sel}, 2'h3);
    chk({full_step_n, wrap_back_out}, 2'h1);
    rd(ppsm_pkg::OFS_CONFIG, 32'h8500);
    tx(8'h3c, 2, 40);
    // A collision aborts the frame before any nibble reaches the partner.
    fast_clash_detect <= 1'b1;
    tx(8'h3c, 0, 0);
    rd(ppsm_pkg::OFS_PHY_STAT, 32'h4004);
    acc(1'b1, ppsm_pkg::OFS_PHY_STAT, 32'h4);
    rd(ppsm_pkg::OFS_PHY_STAT, 32'h4000);
    u_ppsm_link_model.rx(8'h69, 1'b0);
    repeat (8) @(posedge sys_clk);
    rd(ppsm_pkg::OFS_RX_STAT, 32'h196);
    u_ppsm_link_model.rx(8'h0f, 1'b1);
    repeat (8) @(posedge sys_clk);
    rd(ppsm_pkg::OFS_RX_STAT, 32'h21f0);
    chk(bad, 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
